// ---- hdl/psc_target.sv ----
// Passive serial configuration target with AHB-Lite register access
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "psc_target_map.svh"
module psc_target
#(
  parameter int unsigned POR_LONG_CYC  = `PSC_POR_LONG_MS * 1000 * `PSC_CLK_MHZ,
  parameter int unsigned POR_SHORT_CYC = `PSC_POR_SHORT_MS * 1000 * `PSC_CLK_MHZ
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Configuration pins
  input  wire logic        cfg_restart_n,
  input  wire logic        serial_cfg_clock,
  input  wire logic        serial_cfg_data,
  input  wire logic        user_startup_clock,
  input  wire logic        reset_delay_select,
  input  wire logic        weak_pullup_select_n,
  // Open-drain status, done and init-done lines
  input  wire logic        status_in,
  output logic             status_out,
  output logic             status_oe_n,
  input  wire logic        done_in,
  output logic             done_out,
  output logic             done_oe_n,
  output logic             init_done_out,
  output logic             init_done_oe_n,
  // User pin control
  output logic             user_io_tristate,
  output logic             weak_pullup_en,
  output psc_pkg::psc_state_t cfg_state
);
  import psc_pkg::*;

  localparam int unsigned ERR_CYC  = `PSC_ERR_CYC;
  localparam int unsigned OSC_DIV  = `PSC_OSC_DIV;
  localparam int unsigned UCLK_DLY = `PSC_UCLK_DLY_CYC;
  localparam int          INIT_CYC = `PSC_INIT_CYCLES;
  localparam logic [1:0]  CTRL_RST = `PSC_CTRL_RST;

  if (POR_LONG_CYC == 0 || POR_SHORT_CYC == 0 ||
      POR_LONG_CYC >= 2**24 || POR_SHORT_CYC >= 2**24)
  begin : g_chk
    $error("POR cycle counts must be 1 .. 2**24-1");
  end

  // Register index of a bus address, 3'h7 when unmapped
  function automatic logic [2:0] psc_dec(input logic [31:0] a);
    logic [2:0] r;
    r = 3'h7;
    if (a[31:8] == 24'h0)
    begin
      case (a[7:0])
        `PSC_REG_CTRL: r = 3'h0;
        `PSC_REG_LEN:  r = 3'h1;
        `PSC_REG_STAT: r = 3'h2;
        `PSC_REG_WORD: r = 3'h3;
        default:       r = 3'h7;
      endcase
    end
    return r;
  endfunction

  psc_state_t  state_q;
  logic [23:0] cnt_q;
  logic [8:0]  tick_q;
  logic [3:0]  osc_q;
  logic [7:0]  in_s1_q;
  logic [7:0]  in_s2_q;
  logic        sclk_s3_q;
  logic        uclk_s3_q;
  logic [4:0]  bitc_q;
  logic [31:0] shreg_q;
  logic [31:0] chk_q;
  logic [31:0] last_word_q;
  logic [15:0] words_q;
  logic        init_en_q;
  logic        auto_q;
  logic        uclk_sel_q;
  logic [15:0] len_q;
  logic        wr_pend_q;
  logic [2:0]  wr_idx_q;
  logic [31:0] rdata_q;

  // Two-stage synchronisers for every pin input
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      in_s1_q   <= 8'h00;
      in_s2_q   <= 8'h00;
      sclk_s3_q <= 1'b0;
      uclk_s3_q <= 1'b0;
    end
    else
    begin
      in_s1_q   <= {cfg_restart_n, status_in, done_in, serial_cfg_clock,
                    serial_cfg_data, user_startup_clock, reset_delay_select,
                    weak_pullup_select_n};
      in_s2_q   <= in_s1_q;
      sclk_s3_q <= in_s2_q[4];
      uclk_s3_q <= in_s2_q[2];
    end
  end

  logic restart_s, status_s, done_s, sdata_s, dsel_s, pusel_s;
  logic sclk_rise, uclk_rise, osc_tick, init_tick;
  logic word_done, word_last, word_ok;
  logic [31:0] word_next;
  logic [23:0] por_lim;

  assign restart_s = in_s2_q[7];
  assign status_s  = in_s2_q[6];
  assign done_s    = in_s2_q[5];
  assign sdata_s   = in_s2_q[3];
  assign dsel_s    = in_s2_q[1];
  assign pusel_s   = in_s2_q[0];
  assign sclk_rise = in_s2_q[4] & ~sclk_s3_q;
  assign uclk_rise = in_s2_q[2] & ~uclk_s3_q;
  assign osc_tick  = (osc_q == 4'(OSC_DIV - 1));
  // User clock only counts after the enable delay; it never reaches loading
  assign init_tick = uclk_sel_q ? (uclk_rise && cnt_q >= 24'(UCLK_DLY))
                                : osc_tick;
  assign por_lim   = dsel_s ? 24'(POR_SHORT_CYC - 1) : 24'(POR_LONG_CYC - 1);
  assign word_next = {sdata_s, shreg_q[31:1]};
  assign word_done = (state_q == PSC_LOAD) && sclk_rise && (bitc_q == 5'd31);
  assign word_last = word_done && (words_q + 16'h1 == len_q);
  assign word_ok   = ((chk_q ^ word_next) == 32'h0);

  // Free-running internal oscillator model
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || osc_tick)
      osc_q <= 4'h0;
    else
      osc_q <= osc_q + 4'h1;
  end

  // Sequencer
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_q <= PSC_POR;
      cnt_q   <= 24'h0;
      tick_q  <= 9'h0;
    end
    else if (state_q != PSC_POR && !restart_s && state_q != PSC_RESET)
    begin
      state_q <= PSC_RESET;
      cnt_q   <= 24'h0;
      tick_q  <= 9'h0;
    end
    else
    begin
      case (state_q)
        PSC_POR:
        begin
          if (cnt_q >= por_lim)
          begin
            state_q <= PSC_RESET;
            cnt_q   <= 24'h0;
          end
          else
            cnt_q <= cnt_q + 24'h1;
        end
        PSC_RESET:
        begin
          if (restart_s && status_s)
            state_q <= PSC_LOAD;
        end
        PSC_LOAD:
        begin
          if (!status_s)
            state_q <= PSC_RESET;
          else if (word_last)
            state_q <= word_ok ? PSC_RELEASE : PSC_FAULT;
        end
        PSC_RELEASE:
        begin
          if (!status_s)
            state_q <= PSC_RESET;
          else if (done_s)
            state_q <= PSC_INIT;
        end
        PSC_INIT:
        begin
          if (cnt_q < 24'(UCLK_DLY))
            cnt_q <= cnt_q + 24'h1;
          if (init_tick)
          begin
            if (tick_q == 9'(INIT_CYC - 1))
              state_q <= PSC_USER;
            tick_q <= tick_q + 9'h1;
          end
        end
        PSC_FAULT:
        begin
          if (cnt_q < 24'(ERR_CYC - 1))
            cnt_q <= cnt_q + 24'h1;
          else if (auto_q)
          begin
            state_q <= PSC_RESET;
            cnt_q   <= 24'h0;
          end
        end
        PSC_USER:
          state_q <= PSC_USER;
        default:
          state_q <= PSC_POR;
      endcase
    end
  end

  // Serial capture, only while loading
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || state_q != PSC_LOAD)
    begin
      bitc_q  <= 5'h0;
      shreg_q <= 32'h0;
      chk_q   <= 32'h0;
      words_q <= 16'h0;
    end
    else if (sclk_rise)
    begin
      bitc_q  <= bitc_q + 5'h1;
      shreg_q <= word_next;
      if (word_done)
      begin
        chk_q   <= chk_q ^ word_next;
        words_q <= words_q + 16'h1;
      end
    end
  end

  // Init-done enable arrives as bit 0 of the first frame
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || state_q == PSC_RESET || state_q == PSC_POR)
      init_en_q <= 1'b0;
    else if (word_done && words_q == 16'h0 && word_next[0])
      init_en_q <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      last_word_q <= 32'h0;
    else if (word_done)
      last_word_q <= word_next;
  end

  // Pin drive
  assign status_out     = 1'b0;
  assign status_oe_n    = !(state_q == PSC_POR || state_q == PSC_FAULT ||
                            (state_q == PSC_RESET && !restart_s));
  assign done_out       = 1'b0;
  assign done_oe_n      = (state_q == PSC_RELEASE || state_q == PSC_INIT ||
                           state_q == PSC_USER);
  assign init_done_out  = 1'b0;
  assign init_done_oe_n = !(init_en_q && state_q != PSC_USER && state_q != PSC_RESET);
  assign user_io_tristate = (state_q != PSC_USER);
  assign weak_pullup_en = (state_q != PSC_POR) && (state_q != PSC_USER) && !pusel_s;
  assign cfg_state      = state_q;

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 3'h7;
      rdata_q   <= 32'h0;
    end
    else if (hready)
    begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      wr_idx_q  <= psc_dec(haddr);
      if (hsel && htrans[1] && !hwrite)
      begin
        case (psc_dec(haddr))
          3'h0:    rdata_q <= {30'h0, uclk_sel_q, auto_q};
          3'h1:    rdata_q <= {16'h0, len_q};
          3'h2:    rdata_q <= {words_q, 12'h0, init_en_q, 3'(state_q)};
          3'h3:    rdata_q <= last_word_q;
          default: rdata_q <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      auto_q     <= CTRL_RST[`PSC_CTRL_AUTO_BIT];
      uclk_sel_q <= CTRL_RST[`PSC_CTRL_UCLK_BIT];
      len_q      <= `PSC_LEN_RST;
    end
    else if (wr_pend_q)
    begin
      if (wr_idx_q == 3'h0)
      begin
        auto_q     <= hwdata[`PSC_CTRL_AUTO_BIT];
        uclk_sel_q <= hwdata[`PSC_CTRL_UCLK_BIT];
      end
      if (wr_idx_q == 3'h1)
        len_q <= (hwdata[15:0] == 16'h0) ? 16'h1 : hwdata[15:0];
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_por_holds_status: assert property (state_q == PSC_POR |-> !status_oe_n && user_io_tristate)
    else $error("status not held low during power-up");
  chk_por_length: assert property (state_q == PSC_POR && cnt_q >= por_lim |=> state_q == PSC_RESET)
    else $error("power-up delay not honoured");
  chk_restart_reset: assert property (state_q != PSC_POR && !restart_s |=> state_q == PSC_RESET)
    else $error("restart low did not reset");
  chk_user_reconfig: assert property (state_q == PSC_USER && !restart_s |=> !done_oe_n && !status_oe_n)
    else $error("reconfigure did not pull lines low");
  chk_sclk_ignored: assert property (!(state_q == PSC_LOAD && sclk_rise) |=> $stable(bitc_q) || bitc_q == 5'h0)
    else $error("serial clock counted outside loading");
  chk_done_release: assert property (word_last && word_ok && status_s && restart_s |=> done_oe_n ##0 state_q == PSC_RELEASE)
    else $error("done not released after good stream");
  chk_init_start: assert property (state_q == PSC_RELEASE && done_s && status_s && restart_s |=> state_q == PSC_INIT)
    else $error("done rise did not start init");
  chk_init_cycles: assert property (state_q == PSC_USER && $past(state_q) == PSC_INIT |-> $past(tick_q) == INIT_CYC - 1)
    else $error("init did not take 299 cycles");
  chk_init_done_low: assert property (word_done && words_q == 16'h0 && word_next[0] && restart_s |=> !init_done_oe_n)
    else $error("init-done not driven low");
  chk_user_mode_pins: assert property (state_q == PSC_USER |-> init_done_oe_n && !weak_pullup_en && !user_io_tristate)
    else $error("user mode pins wrong");
  chk_fault_release: assert property (state_q == PSC_FAULT && auto_q && cnt_q >= 24'(ERR_CYC - 1) && restart_s |=> status_oe_n)
    else $error("status not released after error timeout");
  chk_por_early: assert property (state_q == PSC_POR && cnt_q < por_lim |=>
                                  state_q == PSC_POR)
    else $error("power-up left before its delay");
  chk_load_status: assert property (state_q == PSC_LOAD |-> status_oe_n)
    else $error("status pulled while loading");
  chk_done_early: assert property (state_q == PSC_LOAD |-> !done_oe_n)
    else $error("done released before a good stream");
  chk_uclk_delay: assert property (state_q == PSC_INIT && uclk_sel_q &&
                                   cnt_q < 24'(UCLK_DLY) |=> $stable(tick_q))
    else $error("user clock counted before its enable delay");
  chk_pullup_select: assert property (state_q == PSC_RESET |-> weak_pullup_en == !pusel_s)
    else $error("weak pull-ups ignore their select");
  chk_sclk_user: assert property (state_q == PSC_USER && sclk_rise |=> $stable(last_word_q))
    else $error("stray serial clock changed stored word");
  chk_init_done_reset: assert property (state_q == PSC_RESET |-> init_done_oe_n)
    else $error("init-done driven during reset");
  chk_held_low: assert property (state_q == PSC_RESET && !status_s |=> state_q == PSC_RESET)
    else $error("left reset while status held low");
endmodule

// ---- hdl/psc_target_map.svh ----
// Address map, field positions, reset values and timing counts of the serial config target
// Notes on behaviour
// - Delay select picks 100 ms or 12 ms power-up
// - Power-up holds status low, user pins floating
// - Memory holding status low delays configuration
// - Prefer short device delay, long memory delay
// - Both parties release the status line after power-up
// - Weak pull-ups off at power-up, then follow select until user mode
// - Restart rise starts reset, load, initialization
// - Restart or status low keeps device reset
// - Restart high releases status, then accept data
// - Data bit captured on serial clock rise
// - Good bitstream releases the done line
// - Done rising starts initialization
// - Internal oscillator clocks initialization unless user clock
// - User clock ignored while loading data
// - User clock: delay, then 299 cycles
// - First frame enable bit drives init-done low
// - Init-done released on entering user mode
// - User mode removes weak pull-ups
// - Error pulls status low, auto-release in 40 us
// - Restart low in user mode reconfigures
`ifndef PSC_TARGET_MAP_SVH
`define PSC_TARGET_MAP_SVH

`define PSC_REG_CTRL        8'h00
`define PSC_REG_LEN         8'h04
`define PSC_REG_STAT        8'h08
`define PSC_REG_WORD        8'h0c
`define PSC_CTRL_AUTO_BIT   0
`define PSC_CTRL_UCLK_BIT   1
`define PSC_CTRL_RST        2'h1
`define PSC_LEN_RST         16'h0004
`define PSC_CLK_MHZ         100
`define PSC_POR_LONG_MS     100
`define PSC_POR_SHORT_MS    12
`define PSC_ERR_TIMEOUT_US  40
`define PSC_OSC_MHZ         10
`define PSC_INIT_CYCLES     299
`define PSC_SCLK_MAX_NS     160
`define PSC_UCLK_DLY_NS     (4 * `PSC_SCLK_MAX_NS)
`define PSC_ERR_CYC         ((`PSC_ERR_TIMEOUT_US * `PSC_CLK_MHZ))
`define PSC_OSC_DIV         (`PSC_CLK_MHZ / `PSC_OSC_MHZ)
`define PSC_UCLK_DLY_CYC    ((`PSC_UCLK_DLY_NS * `PSC_CLK_MHZ + 999) / 1000)

`endif

// ---- hdl/psc_pkg.sv ----
// Types shared by the serial config target
package psc_pkg;
  typedef enum logic [2:0] {
    PSC_POR, PSC_RESET, PSC_LOAD, PSC_RELEASE, PSC_INIT, PSC_USER, PSC_FAULT
  } psc_state_t;
endpackage

// ---- dv/psc_cfg_mem.sv ----
// Behavioural serial configuration memory feeding the target
`timescale 1ns/1ps
module psc_cfg_mem
#(
  parameter int HOLD_NS = 2000
)
(
  // Requests from the bench
  input  wire logic go,
  input  wire logic bad,
  input  wire logic stray,
  // Resolved open-drain lines
  input  wire logic status_line,
  input  wire logic done_line,
  // Serial link and hold output, low pulls the status line
  output logic      sclk,
  output logic      dat,
  output logic      hold_n
);
  logic [31:0] w;

  // Own power-up hold outlasts the target's short delay
  initial
  begin
    sclk = 1'h0;
    dat = 1'h1;
    hold_n = 1'h0;
    #(HOLD_NS) hold_n = 1'h1;
  end

  // Word 0 carries the init-done enable; a bad stream breaks the parity
  // A stray request only clocks zeros, as a misbehaving host would
  // Edges land mid-cycle so the target never samples a pin as it moves
  always @(posedge go or posedge stray)
  begin
    if (stray)
    begin
      #3;
      for (int b = 0; b < 40; b++)
      begin
        dat = 1'h0;
        #80 sclk = 1'h1;
        #80 sclk = 1'h0;
      end
    end
    else
    begin
      wait (status_line === 1'h1);
      #2003;
      for (int i = 0; i < 4; i++)
      begin
        w = (i == 1 || i == 2) ? 32'h5a3c_96e1 : {31'h0, !(bad && i == 3)};
        for (int b = 0; b < 32; b++)
        begin
          if (done_line !== 1'h1)
          begin
            dat = w[b];
            #80 sclk = 1'h1;
            #80 sclk = 1'h0;
          end
        end
      end
      // Released data line must not keep the last bit
      dat = ~dat;
      #(64 * 160);
      if (done_line !== 1'h1)
      begin
        hold_n = 1'h0;
        #1000 hold_n = 1'h1;
      end
    end
  end
endmodule

// ---- dv/psc_target_bench.sv ----
// Self-checking bench for the serial config target
`timescale 1ns/1ps
module psc_target_bench;
  import psc_pkg::*;
  logic        ref_clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic        hreadyout;
  logic        hresp;
  logic        restart_n = 1'h1;
  logic        uclk = 1'h0;
  logic        uclk_en = 1'h0;
  logic        pull_sel_n = 1'h0;
  logic        go = 1'h0;
  logic        bad = 1'h0;
  logic        stray = 1'h0;
  logic        dsel = 1'h1;
  logic        sclk, dat, hold_n;
  logic        status_oe_n, done_oe_n, init_oe_n, tri_st, pu_en;
  psc_state_t  st;
  wire         status_line = status_oe_n & hold_n;
  wire         done_line = done_oe_n;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cyc = 0;

  always #5 ref_clk = ~ref_clk;
  always #20 if (uclk_en) uclk = ~uclk;

  psc_target
  #(
    .POR_LONG_CYC (200),
    .POR_SHORT_CYC(50)
  )
  uut
  (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(1'h1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cfg_restart_n(restart_n), .serial_cfg_clock(sclk), .serial_cfg_data(dat),
    .user_startup_clock(uclk), .reset_delay_select(dsel),
    .weak_pullup_select_n(pull_sel_n), .status_in(status_line), .status_out(),
    .status_oe_n(status_oe_n), .done_in(done_line), .done_out(),
    .done_oe_n(done_oe_n), .init_done_out(), .init_done_oe_n(init_oe_n),
    .user_io_tristate(tri_st), .weak_pullup_en(pu_en), .cfg_state(st)
  );

  psc_cfg_mem mem
  (
    .go(go), .bad(bad), .stray(stray), .status_line(status_line), .done_line(done_line),
    .sclk(sclk), .dat(dat), .hold_n(hold_n)
  );

  task automatic report_and_stop();
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer, entered just after a rising edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge ref_clk);
    while (hreadyout !== 1'h1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hreadyout !== 1'h1) @(posedge ref_clk);
    rd = hrdata;
  endtask

  task automatic wait_st(input psc_state_t s, input int lim);
    for (int i = 0; i < lim && st !== s; i++) @(posedge ref_clk);
    chk(st, s);
  endtask

  task automatic pulse_go();
    go <= 1'h1;
    @(posedge ref_clk);
    go <= 1'h0;
  endtask

  task automatic load_ok();
    pulse_go();
    for (int i = 0; i < 3000 && done_line !== 1'h1; i++) @(posedge ref_clk);
    chk(done_line, 1'h1);
    chk(init_oe_n, 1'h0);
    wait_st(PSC_INIT, 10);
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'h0;
    chk({status_oe_n, done_oe_n, init_oe_n, tri_st, pu_en}, 5'h06);
    chk(st, PSC_POR);
    repeat (45) @(posedge ref_clk);
    chk(st, PSC_POR);
    wait_st(PSC_RESET, 10);
    chk(pu_en, 1'h1);
    pull_sel_n <= 1'h1;
    ahb(1'h0, 32'h0, 32'h0);
    chk(rd, 32'h1);
    ahb(1'h0, 32'h4, 32'h0);
    chk(rd, 32'h4);
    ahb(1'h0, 32'h10, 32'h0);
    chk(rd, 32'h0);
    chk(pu_en, 1'h0);
    chk(st, PSC_RESET);
    pull_sel_n <= 1'h0;
    wait_st(PSC_LOAD, 300);
    chk(status_oe_n, 1'h1);
    load_ok();
    // Internal oscillator: 299 ticks of ten cycles each
    repeat (2900) @(posedge ref_clk);
    chk(st, PSC_INIT);
    wait_st(PSC_USER, 200);
    chk(init_oe_n, 1'h1);
    chk({tri_st, pu_en}, 2'h0);
    // Stray serial clocking in user mode must leave the stored word alone
    stray <= 1'h1;
    @(posedge ref_clk);
    stray <= 1'h0;
    repeat (700) @(posedge ref_clk);
    ahb(1'h0, 32'hc, 32'h0);
    chk(rd, 32'h1);
    ahb(1'h0, 32'h8, 32'h0);
    chk(rd, {28'h0, 1'h1, 3'(PSC_USER)});
    restart_n <= 1'h0;
    repeat (6) @(posedge ref_clk);
    chk({status_oe_n, done_oe_n, tri_st}, 3'h1);
    restart_n <= 1'h1;
    wait_st(PSC_LOAD, 20);
    bad <= 1'h1;
    pulse_go();
    wait_st(PSC_FAULT, 3000);
    chk(status_oe_n, 1'h0);
    wait_st(PSC_LOAD, 4300);
    bad <= 1'h0;
    ahb(1'h1, 32'h0, 32'h3);
    ahb(1'h0, 32'h0, 32'h0);
    chk(rd, 32'h3);
    // User clock runs during loading, then stops in initialization
    uclk_en <= 1'h1;
    load_ok();
    // Rises inside the enable delay must not count
    repeat (40) @(posedge ref_clk);
    uclk_en <= 1'h0;
    repeat (1000) @(posedge ref_clk);
    chk(st, PSC_INIT);
    uclk_en <= 1'h1;
    repeat (1180) @(posedge ref_clk);
    chk(st, PSC_INIT);
    wait_st(PSC_USER, 40);
    // Second power-up with the long delay selected
    dsel <= 1'h0;
    sys_rst <= 1'h1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'h0;
    chk({status_oe_n, done_oe_n, init_oe_n, tri_st, pu_en}, 5'h06);
    repeat (190) @(posedge ref_clk);
    chk(st, PSC_POR);
    wait_st(PSC_RESET, 20);
    report_and_stop();
  end
endmodule
